// [design/rtm_core.sv]
`timescale 1ns/10ps
module rtm_core (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // pins
    input wire logic subsystem_fail_input,
    // host configuration
    input wire logic host_ssf,
    input wire logic bus_ctrl_en,
    // message completion from protocol logic
    input wire logic msg_done,
    input wire logic msg_bcst,
    input wire logic msg_fault,
    input wire logic [4:0] msg_wc,
    input wire logic [5:0] msg_rcvd,
    input wire logic msg_chan_b,
    input wire logic [15:0] msg_cmd,
    // incoming word write filter
    input wire logic [5:0] word_idx,
    output logic word_wr_ok,
    // mode code request
    input wire logic mc_valid,
    input wire logic [4:0] mc_code,
    input wire logic mc_tx,
    input wire logic mc_bcst,
    input wire logic mc_chan_b,
    input wire logic [15:0] mc_cw,
    input wire logic [15:0] mc_cmd,
    input wire logic [15:0] mc_vector,
    // self test engine
    input wire logic bist_done,
    input wire logic bist_fail,
    input wire logic [15:0] bist_result,
    output logic bist_start,
    // results
    output logic [15:0] msw,
    output logic msw_valid,
    output logic [15:0] bus_status,
    output logic [15:0] cw_new,
    output logic [8:0] mc_desc_addr,
    output logic mc_illegal,
    output logic irq,
    output logic hp_irq,
    output logic dbc_accept,
    output logic [15:0] tx_word,
    output logic [2:0] tx_kind,
    output logic tx_valid,
    output logic chan_a_dis,
    output logic chan_b_dis,
    output logic tf_inhibit,
    output logic proto_reset,
    output logic self_test_fail_pin
);
    logic ssf_m_q, ssf_q;
    logic [15:0] tick_q;
    logic [7:0] tag_q;
    logic [15:0] last_stat_q, last_cmd_q, bit_reg_q;
    logic tf_q;
    logic [4:0] wc_q;
    logic mismatch;
    logic nd;
    logic ill;
    logic accept_dbc;
    logic [6:0] idx;

    // fail input synchroniser
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ssf_m_q <= 1'b0;
            ssf_q <= 1'b0;
        end
        else
        begin
            ssf_m_q <= subsystem_fail_input;
            ssf_q <= ssf_m_q;
        end
    end

    // time tag, wraps at 256
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            tick_q <= 16'h0000;
            tag_q <= 8'h00;
        end
        else if (tick_q == 16'(rtm_pkg::TAG_STEP_CYC - 1))
        begin
            tick_q <= 16'h0000;
            tag_q <= tag_q + 8'h01; // RQ6 RQ25
        end
        else
            tick_q <= tick_q + 16'h0001;
    end

    // surplus words withheld
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            wc_q <= 5'h00;
        else if (msg_done) // count of the completed command
            wc_q <= msg_cmd[4:0];
        else if (mc_valid)
            wc_q <= 5'h01;
    end
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            word_wr_ok <= 1'b0;
        else // zero field means 32 words
            word_wr_ok <= ({1'b0, word_idx} < ((wc_q == 5'h00) ? 7'd32
                          : {2'b00, wc_q})); // RQ5
    end

    // count of 0 in command means 32
    assign mismatch = msg_rcvd != ((msg_wc == 5'h00) ? 6'd32 : {1'b0, msg_wc});

    // message status word
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            msw <= 16'h0000;
            msw_valid <= 1'b0;
        end
        else
        begin
            msw_valid <= msg_done;
            if (msg_done)
            begin
                msw[rtm_pkg::MSW_FAIL] <= ssf_q | host_ssf; // RQ1
                msw[rtm_pkg::MSW_BCST] <= msg_bcst; // RQ2
                msw[rtm_pkg::MSW_ERR] <= msg_fault | mismatch; // RQ3 RQ4
                msw[12:rtm_pkg::MSW_WC_LO] <= msg_wc; // RQ4
                msw[7:0] <= tag_q; // RQ6
            end
        end
    end

    // bus status word and last message records
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            bus_status <= 16'h0000;
            last_stat_q <= 16'h0000;
            last_cmd_q <= 16'h0000;
        end
        else
        begin
            bus_status[rtm_pkg::ST_TF] <= tf_q & ~tf_inhibit; // RQ16 RQ18
            if (msg_done)
            begin
                bus_status[rtm_pkg::ST_MSGERR] <= msg_fault | mismatch; // RQ5
                bus_status[rtm_pkg::ST_BCST] <= msg_bcst;
                bus_status[rtm_pkg::ST_DBCA] <= 1'b0;
                last_stat_q <= bus_status;
                last_cmd_q <= msg_cmd;
            end
            else if (mc_valid)
            begin
                bus_status[rtm_pkg::ST_MSGERR] <= ill;
                bus_status[rtm_pkg::ST_DBCA] <= accept_dbc; // RQ13
                last_cmd_q <= mc_cmd;
            end
        end
    end

    // decode of descriptor control word
    assign nd = ~mc_code[4]; // RQ7
    assign idx = mc_cw[6:0];
    always_comb
    begin
        if (nd)
            ill = mc_cw[rtm_pkg::CW_ILL_ND]
                | (mc_bcst & mc_cw[rtm_pkg::CW_BCILL_ND]); // RQ9
        else
            ill = (mc_bcst & mc_cw[rtm_pkg::CW_BCILL_D])
                | (mc_tx & mc_cw[rtm_pkg::CW_TXILL_D])
                | (~mc_tx & mc_cw[rtm_pkg::CW_RXILL_D]); // RQ10
        accept_dbc = !ill && mc_code == rtm_pkg::MC_DBC && bus_ctrl_en;
    end

    // descriptor address, index update and interrupts
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            mc_desc_addr <= rtm_pkg::MODE_DESC_BASE;
            cw_new <= 16'h0000;
            mc_illegal <= 1'b0;
            irq <= 1'b0;
            hp_irq <= 1'b0;
            dbc_accept <= 1'b0;
        end
        else
        begin
            irq <= 1'b0;
            hp_irq <= 1'b0;
            dbc_accept <= 1'b0;
            mc_illegal <= mc_valid & ill;
            if (mc_valid)
            begin
                mc_desc_addr <= rtm_pkg::MODE_DESC_BASE
                              + {3'b000, mc_code[3:0], 2'b00}; // RQ8
                cw_new <= mc_cw;
                if (!nd)
                    cw_new[6:0] <= (idx == 7'h00) ? 7'h00 : idx - 7'h01; //RQ24
                if (!ill)
                begin
                    irq <= (nd ? mc_cw[rtm_pkg::CW_IRQ_ND]
                              : mc_cw[rtm_pkg::CW_IRQ_D]) // RQ12 RQ14
                         | (!nd && idx == 7'h01
                              && mc_cw[rtm_pkg::CW_IRQ_IDX0]); // RQ11
                    hp_irq <= accept_dbc; // RQ13
                    dbc_accept <= accept_dbc; // RQ13
                end
            end
        end
    end

    // mode code actions
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            chan_a_dis <= 1'b0;
            chan_b_dis <= 1'b0;
            tf_inhibit <= 1'b0;
            proto_reset <= 1'b0;
            bist_start <= 1'b0;
            tx_word <= 16'h0000;
            tx_kind <= rtm_pkg::RTM_TX_NONE;
            tx_valid <= 1'b0;
        end
        else
        begin
            proto_reset <= 1'b0;
            bist_start <= 1'b0;
            tx_valid <= 1'b0;
            tx_kind <= rtm_pkg::RTM_TX_NONE;
            if (mc_valid && !ill)
            begin
                unique case (mc_code)
                    rtm_pkg::MC_TXSTAT:
                    begin
                        tx_valid <= 1'b1;
                        tx_kind <= rtm_pkg::RTM_TX_STATUS;
                        tx_word <= last_stat_q; // RQ15
                    end
                    rtm_pkg::MC_SELFTEST: bist_start <= 1'b1; // RQ16
                    rtm_pkg::MC_SHUT:
                    begin
                        chan_a_dis <= mc_chan_b; // RQ17
                        chan_b_dis <= ~mc_chan_b;
                    end
                    rtm_pkg::MC_OVSHUT:
                    begin
                        chan_a_dis <= 1'b0; // RQ17
                        chan_b_dis <= 1'b0;
                    end
                    rtm_pkg::MC_INHTF: tf_inhibit <= 1'b1; // RQ18
                    rtm_pkg::MC_OVINHTF: tf_inhibit <= 1'b0; // RQ18
                    rtm_pkg::MC_RESET: proto_reset <= 1'b1; // RQ19
                    rtm_pkg::MC_VECTOR:
                    begin
                        tx_valid <= 1'b1;
                        tx_kind <= rtm_pkg::RTM_TX_VECTOR;
                        tx_word <= mc_vector; // RQ20
                    end
                    rtm_pkg::MC_LASTCMD:
                    begin
                        tx_valid <= 1'b1;
                        tx_kind <= rtm_pkg::RTM_TX_LASTCMD;
                        tx_word <= last_cmd_q; // RQ22
                    end
                    rtm_pkg::MC_BITWORD:
                    begin
                        tx_valid <= 1'b1;
                        tx_kind <= rtm_pkg::RTM_TX_BITWORD;
                        tx_word <= bit_reg_q; // RQ22
                    end
                    default: ; // RQ21 RQ23
                endcase
            end
        end
    end

    // self test result capture
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            bit_reg_q <= 16'h0000;
            tf_q <= 1'b0;
            self_test_fail_pin <= 1'b0;
        end
        else if (bist_done)
        begin
            bit_reg_q <= bist_result; // RQ16
            tf_q <= bist_fail;
            self_test_fail_pin <= bist_fail;
        end
    end

    // mismatch shows in both status words one cycle after completion
    property p_msg_err;
        @(posedge core_clk) disable iff (!resetn)
        msg_done |=> msw[13] == $past(msg_fault | mismatch)
                     && bus_status[10] == msw[13];
    endproperty
    a_msg_err: assert property (p_msg_err) else $error("msg error"); // RQ5

    property p_tag;
        @(posedge core_clk) disable iff (!resetn)
        msg_done |=> msw[7:0] == $past(tag_q) && msw[12:8] == $past(msg_wc);
    endproperty
    a_tag: assert property (p_tag) else $error("tag or count wrong"); // RQ6

    property p_dbc;
        @(posedge core_clk) disable iff (!resetn)
        dbc_accept |-> $past(bus_ctrl_en) && hp_irq && bus_status[1];
    endproperty
    a_dbc: assert property (p_dbc) else $error("dbc accept"); // RQ13

    property p_shut;
        @(posedge core_clk) disable iff (!resetn)
        mc_valid && !ill && mc_code == 5'h04 |=> chan_a_dis != chan_b_dis;
    endproperty
    a_shut: assert property (p_shut) else $error("shutdown"); // RQ17

    property p_inh;
        @(posedge core_clk) disable iff (!resetn)
        tf_inhibit |=> !bus_status[0];
    endproperty
    a_inh: assert property (p_inh) else $error("tf inhibit"); // RQ18

    property p_idx;
        @(posedge core_clk) disable iff (!resetn)
        mc_valid && !nd |=> cw_new[6:0] == (($past(mc_cw[6:0]) == 7'h00)
                            ? 7'h00 : $past(mc_cw[6:0]) - 7'h01);
    endproperty
    a_idx: assert property (p_idx) else $error("index"); // RQ24

    property p_ill;
        @(posedge core_clk) disable iff (!resetn)
        mc_valid && nd && mc_cw[13] |=> mc_illegal && !irq && !tx_valid;
    endproperty
    a_ill: assert property (p_ill) else $error("illegal"); // RQ9

    property p_fail;
        @(posedge core_clk) disable iff (!resetn)
        host_ssf && msg_done |=> msw[15];
    endproperty
    a_fail: assert property (p_fail) else $error("fail bit"); // RQ1
endmodule

// [design/rtm_pkg.sv]
// Overview of operation
// RQ1: status bit 15 set if subsystem fail input or host fail bit active
// RQ2: status bit 14 set for broadcast messages
// RQ3: status bit 13 set on sync, bit count, word count or Manchester fault
// RQ4: bits 12-8 hold command word count; mismatch raises message error
// RQ5: surplus words not written; mismatch sets bus status message error
// RQ6: time tag count in bits 7-0 after completion, 64 us per step
// RQ7: sixteen descriptors; descriptor n serves codes n and n plus 16
// RQ8: mode descriptors start at word 0100H of 320-word descriptor space
// RQ9: no-data codes: bit 15 interrupt, 14 broadcast illegal, 13 illegal
// RQ10: data codes: bit 11 broadcast, 10 transmit, 9 receive illegal; 8 irq
// RQ11: bits 6-0 index for data codes; bit 7 interrupt when index is zero
// RQ12: no-data codes executed autonomously; interrupt on success if enabled
// RQ13: code 0 accepted only with bus control enable; sets acceptance, irq
// RQ14: code 1 raises interrupt if descriptor enables it
// RQ15: code 2 transmits status word of last message
// RQ16: code 3 starts self test; result, fail pin, irq, terminal flag; code raises no irq when the test completes
// RQ17: code 4 disables opposite channel; code 5 re-enables it
// RQ18: code 6 inhibits terminal flag; code 7 removes inhibition
// RQ19: code 8 resets encoder, decoders and protocol logic
// RQ20: code 16 transmits vector word at descriptor data pointer
// RQ21: code 17 only stores the data word
// RQ22: code 18 sends last command then status; code 19 sends test result
// RQ23: codes 9-15 and 22-31 reserved, no action
// RQ24: index decremented after each message, stopping at zero
// RQ25: time tag counter wraps modulo 256
package rtm_pkg;
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned TAG_STEP_US = 64;
    localparam int unsigned TAG_STEP_CYC = CLK_HZ / 1_000_000 * TAG_STEP_US;
    localparam logic [8:0] DESC_SPACE_WORDS = 9'h140;
    localparam logic [8:0] MODE_DESC_BASE = 9'h100;
    localparam int unsigned MSW_FAIL = 15;
    localparam int unsigned MSW_BCST = 14;
    localparam int unsigned MSW_ERR = 13;
    localparam int unsigned MSW_WC_LO = 8;
    localparam int unsigned CW_IRQ_ND = 15;
    localparam int unsigned CW_BCILL_ND = 14;
    localparam int unsigned CW_ILL_ND = 13;
    localparam int unsigned CW_BCILL_D = 11;
    localparam int unsigned CW_TXILL_D = 10;
    localparam int unsigned CW_RXILL_D = 9;
    localparam int unsigned CW_IRQ_D = 8;
    localparam int unsigned CW_IRQ_IDX0 = 7;
    localparam int unsigned ST_MSGERR = 10;
    localparam int unsigned ST_BCST = 4;
    localparam int unsigned ST_DBCA = 1;
    localparam int unsigned ST_TF = 0;
    localparam logic [4:0] MC_DBC = 5'h00;
    localparam logic [4:0] MC_SYNC = 5'h01;
    localparam logic [4:0] MC_TXSTAT = 5'h02;
    localparam logic [4:0] MC_SELFTEST = 5'h03;
    localparam logic [4:0] MC_SHUT = 5'h04;
    localparam logic [4:0] MC_OVSHUT = 5'h05;
    localparam logic [4:0] MC_INHTF = 5'h06;
    localparam logic [4:0] MC_OVINHTF = 5'h07;
    localparam logic [4:0] MC_RESET = 5'h08;
    localparam logic [4:0] MC_VECTOR = 5'h10;
    localparam logic [4:0] MC_SYNCD = 5'h11;
    localparam logic [4:0] MC_LASTCMD = 5'h12;
    localparam logic [4:0] MC_BITWORD = 5'h13;
    typedef enum logic [2:0] {
        RTM_TX_NONE, RTM_TX_STATUS, RTM_TX_VECTOR, RTM_TX_LASTCMD,
        RTM_TX_BITWORD
    } rtm_tx_t;
endpackage

// [verif/rtm_bc_model.sv]
`timescale 1ns/10ps
module rtm_bc_model #(
    parameter logic [15:0] VEC = 16'h3c5a
) (
    // clock
    input wire logic core_clk,
    // mode code command
    output logic mc_valid,
    output logic [4:0] mc_code,
    output logic mc_tx,
    output logic mc_bcst,
    output logic mc_chan_b,
    output logic [15:0] mc_cw,
    output logic [15:0] mc_cmd,
    output logic [15:0] mc_vector,
    // message completion
    output logic msg_done,
    output logic msg_bcst,
    output logic msg_fault,
    output logic [4:0] msg_wc,
    output logic [5:0] msg_rcvd,
    output logic msg_chan_b,
    output logic [15:0] msg_cmd
);
    // idle: strobes low, qualifiers carry junk
    initial
    begin
        mc_valid = 1'b0;
        msg_done = 1'b0;
        {mc_code, mc_tx, mc_bcst, mc_chan_b, mc_cw} = 24'h5a_a55a;
        mc_cmd = 16'ha5a5;
        mc_vector = ~VEC;
        {msg_wc, msg_rcvd, msg_bcst, msg_fault, msg_chan_b} = 14'h2aaa;
        msg_cmd = 16'h5a5a;
    end

    // mode code command held over one rising edge, then scrambled
    task mc(input logic [4:0] c, input logic t, b, ch,
            input logic [15:0] w);
        @(negedge core_clk);
        mc_valid = 1'b1;
        {mc_code, mc_tx, mc_bcst, mc_chan_b, mc_cw} = {c, t, b, ch, w};
        mc_cmd = {5'h05, t, 5'h1f, c};
        mc_vector = VEC;
        @(negedge core_clk);
        mc_valid = 1'b0;
        {mc_code, mc_tx, mc_bcst, mc_chan_b, mc_cw} = ~{c, t, b, ch, w};
        mc_cmd = ~mc_cmd;
        mc_vector = ~VEC;
    endtask

    // end of a data message as seen by the protocol logic
    task msg(input logic [4:0] wc, input logic [5:0] n, input logic b, f);
        @(negedge core_clk);
        msg_done = 1'b1;
        {msg_wc, msg_rcvd, msg_bcst, msg_fault, msg_chan_b} =
            {wc, n, b, f, 1'b0};
        msg_cmd = {5'h05, 1'b0, 5'h02, wc};
        @(negedge core_clk);
        msg_done = 1'b0;
        {msg_wc, msg_rcvd, msg_bcst, msg_fault, msg_chan_b} =
            ~{wc, n, b, f, 1'b0};
        msg_cmd = ~msg_cmd;
    endtask
endmodule

// [verif/testbench.sv]
`timescale 1ns/10ps
module testbench;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic subsystem_fail_input = 1'b0;
    logic host_ssf = 1'b0;
    logic bus_ctrl_en = 1'b1;
    logic bist_done = 1'b0;
    logic bist_fail = 1'b1;
    logic [5:0] word_idx = 6'h00;
    logic [15:0] bist_result = 16'ha5c3;
    logic mc_valid, mc_tx, mc_bcst, mc_chan_b;
    logic msg_done, msg_bcst, msg_fault, msg_chan_b;
    logic [4:0] mc_code, msg_wc;
    logic [5:0] msg_rcvd;
    logic [15:0] mc_cw, mc_cmd, mc_vector, msg_cmd;
    logic word_wr_ok, bist_start, msw_valid, mc_illegal, irq, hp_irq;
    logic dbc_accept, tx_valid, chan_a_dis, chan_b_dis, tf_inhibit;
    logic proto_reset, self_test_fail_pin;
    logic [15:0] msw, bus_status, cw_new, tx_word, word_s;
    logic [8:0] mc_desc_addr;
    logic [2:0] tx_kind, kind_s;
    logic [7:0] seen;
    logic [7:0] t0;
    int errors = 0;
    int samples_checked = 0;
    // code, tx, bcst, control word, pulses, care mask, tx kind
    localparam logic [37:0] ROWS [17] = '{
        {5'h00, 2'b10, 16'h0000, 6'h10, 6'h36, 3'h0},
        {5'h01, 2'b10, 16'h8000, 6'h08, 6'h3e, 3'h0},
        {5'h01, 2'b10, 16'h0000, 6'h00, 6'h3e, 3'h0},
        {5'h02, 2'b10, 16'h0000, 6'h01, 6'h27, 3'h1},
        {5'h03, 2'b10, 16'h0000, 6'h02, 6'h26, 3'h0},
        {5'h08, 2'b10, 16'h0000, 6'h04, 6'h26, 3'h0},
        {5'h10, 2'b10, 16'h0000, 6'h01, 6'h21, 3'h2},
        {5'h12, 2'b10, 16'h0000, 6'h01, 6'h21, 3'h3},
        {5'h13, 2'b10, 16'h0000, 6'h01, 6'h21, 3'h4},
        {5'h01, 2'b10, 16'h2000, 6'h20, 6'h28, 3'h0},
        {5'h01, 2'b11, 16'h4000, 6'h20, 6'h28, 3'h0},
        {5'h11, 2'b00, 16'h0200, 6'h20, 6'h28, 3'h0},
        {5'h10, 2'b10, 16'h0400, 6'h20, 6'h20, 3'h0},
        {5'h11, 2'b01, 16'h0800, 6'h20, 6'h20, 3'h0},
        {5'h11, 2'b00, 16'h0100, 6'h08, 6'h28, 3'h0},
        {5'h09, 2'b10, 16'h0000, 6'h00, 6'h3e, 3'h0},
        {5'h16, 2'b00, 16'h0000, 6'h00, 6'h3e, 3'h0}
    };

    rtm_core u_dut (.*);
    rtm_bc_model u_bc (.*);

    // 50 MHz clock
    always #10 core_clk = ~core_clk;

    task cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    task chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // gather one-cycle pulses and transmitted words
    task watch(input int n);
        seen = 8'h00;
        repeat (n)
        begin
            @(posedge core_clk);
            #1;
            seen |= {msw_valid, hp_irq, mc_illegal, dbc_accept, irq,
                proto_reset, bist_start, tx_valid};
            if (tx_valid === 1'b1)
            begin
                word_s = tx_word;
                kind_s = tx_kind;
            end
        end
    endtask

    task mcw(input logic [4:0] c, input logic t, b, ch,
             input logic [15:0] w);
        fork
            u_bc.mc(c, t, b, ch, w);
            watch(4);
        join
        @(negedge core_clk);
    endtask

    // message completion with pulse gathering, ends on a falling edge
    task mgw(input logic [4:0] wc, input logic [5:0] n, input logic b, f);
        fork
            u_bc.msg(wc, n, b, f);
            watch(4);
        join
        @(negedge core_clk);
    endtask

    task close_out;
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // self-test engine answers a start after a few cycles
    always @(negedge core_clk)
        if (bist_start === 1'b1)
        begin
            cyc(3);
            bist_done = 1'b1;
            cyc(1);
            bist_done = 1'b0;
        end

    // hang guard
    initial
    begin
        cyc(20000);
        errors++;
        close_out;
    end

    // main sequence
    initial
    begin
        logic [37:0] r;
        cyc(5);
        resetn = 1'b1;
        chk(16'(mc_desc_addr), 16'h0100);
        chk(msw, 16'h0000);
        chk(16'({chan_a_dis, chan_b_dis, self_test_fail_pin}), 16'h0000);
        cyc(3);
        foreach (ROWS[i])
        begin
            r = ROWS[i];
            mcw(r[37:33], r[32], r[31], 1'b0, r[30:15]);
            chk(16'(seen & r[8:3]), 16'(r[14:9] & r[8:3]));
            if (r[9])
                chk(16'(kind_s), 16'(r[2:0]));
            chk(16'(mc_desc_addr), 16'(9'h100 + {r[36:33], 2'b00}));
        end
        mcw(5'h00, 1'b1, 1'b0, 1'b0, 16'h0000);
        chk(16'(bus_status[rtm_pkg::ST_DBCA]), 16'h0001);
        chk(16'(seen[6]), 16'h0001);
        bus_ctrl_en = 1'b0;
        mcw(5'h00, 1'b1, 1'b0, 1'b0, 16'h0000);
        chk(16'(seen[4]), 16'h0000);
        chk(16'({seen[6], bus_status[rtm_pkg::ST_DBCA]}), 16'h0000);
        mcw(5'h04, 1'b1, 1'b0, 1'b0, 16'h0000);
        chk(16'({chan_a_dis, chan_b_dis}), 16'h0001);
        mcw(5'h05, 1'b1, 1'b0, 1'b0, 16'h0000);
        chk(16'({chan_a_dis, chan_b_dis}), 16'h0000);
        mcw(5'h04, 1'b1, 1'b0, 1'b1, 16'h0000);
        chk(16'({chan_a_dis, chan_b_dis}), 16'h0002);
        chk(16'(self_test_fail_pin), 16'h0001);
        chk(16'(bus_status[rtm_pkg::ST_TF]), 16'h0001);
        mcw(5'h06, 1'b1, 1'b0, 1'b0, 16'h0000);
        cyc(2);
        chk(16'({tf_inhibit, bus_status[rtm_pkg::ST_TF]}), 16'h0002);
        mcw(5'h07, 1'b1, 1'b0, 1'b0, 16'h0000);
        chk(16'(tf_inhibit), 16'h0000);
        mcw(5'h13, 1'b1, 1'b0, 1'b0, 16'h0000);
        chk(word_s, 16'ha5c3);
        mcw(5'h10, 1'b1, 1'b0, 1'b0, 16'h0000);
        chk(word_s, 16'h3c5a);
        // index counts down to zero and holds there
        mcw(5'h11, 1'b0, 1'b0, 1'b0, 16'h0082);
        chk(cw_new, 16'h0081);
        chk(16'(seen[3]), 16'h0000);
        mcw(5'h11, 1'b0, 1'b0, 1'b0, 16'h0081);
        chk(cw_new, 16'h0080);
        chk(16'(seen[3]), 16'h0001);
        mcw(5'h11, 1'b0, 1'b0, 1'b0, 16'h0080);
        chk(cw_new, 16'h0080);
        // surplus word, broadcast, then a fault
        mgw(5'h03, 6'h04, 1'b1, 1'b0);
        chk(16'(msw[15:8]), 16'h0063);
        chk(16'(seen[7]), 16'h0001);
        chk(16'(bus_status[rtm_pkg::ST_MSGERR]), 16'h0001);
        word_idx = 6'h02;
        cyc(2);
        chk(16'(word_wr_ok), 16'h0001);
        word_idx = 6'h03;
        cyc(2);
        chk(16'(word_wr_ok), 16'h0000);
        mgw(5'h02, 6'h02, 1'b0, 1'b1);
        chk(16'(msw[15:8]), 16'h0022);
        t0 = msw[7:0];
        subsystem_fail_input = 1'b1;
        // next completion 3199 cycles later, one cycle short of a tag step
        cyc(3195);
        mgw(5'h02, 6'h02, 1'b0, 1'b0);
        chk(16'(msw[15:8]), 16'h0082);
        chk(16'(msw[7:0]), 16'(t0 + 8'h01));
        chk(16'(bus_status[rtm_pkg::ST_MSGERR]), 16'h0000);
        subsystem_fail_input = 1'b0;
        host_ssf = 1'b1;
        cyc(4);
        mgw(5'h02, 6'h02, 1'b0, 1'b0);
        chk(16'(msw[15]), 16'h0001);
        // reset in mid-run clears shutdown state
        resetn = 1'b0;
        cyc(1);
        resetn = 1'b1;
        chk(16'(chan_a_dis), 16'h0000);
        chk(16'(mc_desc_addr), 16'h0100);
        cyc(2);
        chk(msw, 16'h0000);
        chk(16'({tf_inhibit, self_test_fail_pin}), 16'h0000);
        close_out;
    end
endmodule
